// [rtl/bct_pkg.sv]
// constants shared by the bridge clock, threshold and timeout register block
package bct_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W           = 12;
  localparam logic [11:0] ADDR_CLK_STRAPS  = 12'h048;
  localparam logic [11:0] ADDR_BUF_THRES   = 12'h04c;
  localparam logic [11:0] ADDR_COMPLETION_TIMEOUT_CONTROL = 12'h050;
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h060;
  localparam logic [11:0] ADDR_IRQ_MASK    = 12'h064;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] CLK_STRAPS_RESET  = 32'h0000_0100;
  localparam logic [31:0] BUF_THRES_RESET   = 32'h0000_0307;
  localparam logic [31:0] COMPLETION_TIMEOUT_CONTROL_RESET = 32'h8009_8968;
  localparam int          PLL_RATE_BIT      = 8;
  localparam int          SRC_SEL_BIT       = 3;
  localparam int          SPEED_LSB         = 0;
  localparam int          ALLOC_LSB         = 8;
  localparam int          THRES_LSB         = 0;
  localparam int          TIMER_EN_BIT      = 31;
  localparam int          TIMER_VALUE_LSB   = 0;

  // ----------------------------------------------------------------
  // secondary clock speed codes (two low bits of the speed code)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SPEED_25, SPEED_33, SPEED_50, SPEED_66} bct_speed_type;

  // ----------------------------------------------------------------
  // buffering
  // ----------------------------------------------------------------
  localparam logic [12:0] ALLOC_BASE_BYTES = 13'h0080;
  localparam logic [7:0]  POST_STEP_BYTES  = 8'h10;
  localparam logic [4:0]  POST_MAX_CODE    = 5'h07;
  localparam int          LEN_W            = 13;
  localparam int          BEAT_W           = 8;

  // ----------------------------------------------------------------
  // completion timers: value counts 16 ns units, timer runs in 8 ns
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          TIMER_UNIT_NS = 16;
  localparam int          TIMER_SUB_NS  = TIMER_UNIT_NS / 2;
  localparam logic [32:0] TIMER_STEP    = 33'(CLK_PERIOD_NS / TIMER_SUB_NS);
  localparam int          NUM_TAGS      = 4;
  localparam int          TAG_W         = 2;

  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int IRQ_W           = 2;
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_FORWARD_BIT = 1;

endpackage

// [rtl/bct_cpl_timer.sv]
// one completion timeout counter for a single outstanding request tag
`timescale 1ns/10ps
module bct_cpl_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // control
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic        ack,
  input  wire logic        enable,
  input  wire logic [30:0] limit,
  // status
  output logic             busy,
  output logic             pending
);
  import bct_pkg::*;

  typedef struct packed {
    logic        busy;
    logic        pending;
    logic [32:0] count;
  } bct_timer_type;

  bct_timer_type state;
  bct_timer_type next_state;

  // count in 8 ns steps so a 40 ns clock adds an exact whole number
  always_comb begin
    next_state = state;
    if (state.busy && enable) begin
      if (state.count >= {1'b0, limit, 1'b0}) begin
        next_state.pending = 1'b1;
        next_state.busy    = 1'b0;
      end else begin
        next_state.count = state.count + TIMER_STEP;
      end
    end
    if (ack || !enable) begin
      next_state.pending = 1'b0;
    end
    if (stop) begin
      next_state.busy = 1'b0;
    end
    if (start) begin
      next_state.busy    = 1'b1;
      next_state.pending = 1'b0;
      next_state.count   = '0;
    end
    if (rst) begin
      next_state = '0;
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign busy    = state.busy;
  assign pending = state.pending;

endmodule

// [rtl/bct_regs.sv]
// bridge clock select, upstream buffer threshold and completion timeout block
// ----------------------------------------------------------------
// Overview of operation
// - pll rate bit: 400 MHz set, 200 cleared
// - source select zero: strap picks 33/66 MHz
// - source select one: speed code sets clock
// - speed code top bit ignored, 25/33/50/66
// - allocation limit code: 128 to 1024 bytes
// - reserve minimum of limit and length
// - forward posted data once threshold reached
// - threshold code: 16-byte steps from 16
// - other events may also forward data
// - enabled timer expiry completes with unsupported
// - reset: 10 ms timeout, checking enabled
// ----------------------------------------------------------------
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
module bct_regs (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // register port
  input  wire logic [bct_pkg::ADDR_W-1:0]     addr,
  input  wire logic [31:0]                    wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic      [31:0]                    rdata,
  // interrupt
  output logic                                irq,
  // secondary clock control
  input  wire logic                           speed_66_strap,
  output logic                                pll_rate_select,
  output bct_pkg::bct_speed_type              secondary_clock_speed,
  // upstream non-posted requests and completions
  input  wire logic                           np_issue,
  input  wire logic [bct_pkg::TAG_W-1:0]      np_tag,
  input  wire logic [bct_pkg::LEN_W-1:0]      np_len,
  input  wire logic                           cpl_valid,
  input  wire logic [bct_pkg::TAG_W-1:0]      cpl_tag,
  output logic                                reserve_valid,
  output logic      [bct_pkg::LEN_W-1:0]      reserve_bytes,
  output logic      [bct_pkg::NUM_TAGS-1:0]   tag_busy,
  output logic                                completion_timeout_control,
  output logic      [bct_pkg::TAG_W-1:0]      completion_timeout_control_tag,
  // upstream posted writes
  input  wire logic                           post_valid,
  input  wire logic [bct_pkg::BEAT_W-1:0]     post_bytes,
  input  wire logic                           post_flush,
  output logic                                post_forward,
  output logic      [8:0]                     post_forward_bytes
);
  import bct_pkg::*;

  typedef struct packed {
    logic                 pll_rate;
    logic                 src_sel;
    logic [2:0]           speed_code;
    logic [1:0]           alloc_code;
    logic [4:0]           thres_code;
    logic                 timer_en;
    logic [30:0]          timer_value;
    logic [IRQ_W-1:0]     irq_status;
    logic [IRQ_W-1:0]     irq_mask;
    logic [2:0]           strap_sync;
    logic                 strap_level;
    bct_speed_type        sec_speed;
    logic [31:0]          rdata;
    logic                 reserve_valid;
    logic [LEN_W-1:0]     reserve_bytes;
    logic [8:0]           post_count;
    logic                 post_forward;
    logic [8:0]           post_forward_bytes;
    logic                 completion_timeout_control;
    logic [TAG_W-1:0]     completion_timeout_control_tag;
  } bct_state_type;

  bct_state_type        state;
  bct_state_type        next_state;
  logic [LEN_W-1:0]     alloc_limit;
  logic [7:0]           post_threshold;
  logic [8:0]           post_sum;
  logic                 post_fire;
  logic [NUM_TAGS-1:0]  timer_pending;
  logic [NUM_TAGS-1:0]  timer_ack;
  logic [IRQ_W-1:0]     irq_events;
  logic [IRQ_W-1:0]     irq_w1c;

  // ----------------------------------------------------------------
  // derived settings
  // ----------------------------------------------------------------

  // allocation limit doubles from 128 bytes per code step
  assign alloc_limit = ALLOC_BASE_BYTES << state.alloc_code;

  // codes above seven are clamped to the largest documented size
  assign post_threshold = (state.thres_code > POST_MAX_CODE)
                        ? (8'(POST_MAX_CODE) + 8'h01) * POST_STEP_BYTES
                        : (8'(state.thres_code) + 8'h01) * POST_STEP_BYTES;

  assign post_sum = state.post_count + (post_valid ? {1'b0, post_bytes} : 9'h000);

  // forward decision taken apart from next_state so the status logic forms no loop
  assign post_fire = (post_sum >= {1'b0, post_threshold}) || (post_flush && post_sum != 9'h000);

  // ----------------------------------------------------------------
  // per-tag completion timers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TAGS; gi++) begin : g_timer
      bct_cpl_timer u_timer (
        .clk     (clk),
        .rst     (rst),
        .start   (np_issue && np_tag == TAG_W'(gi)),
        .stop    (cpl_valid && cpl_tag == TAG_W'(gi)),
        .ack     (timer_ack[gi]),
        .enable  (state.timer_en),
        .limit   (state.timer_value),
        .busy    (tag_busy[gi]),
        .pending (timer_pending[gi])
      );
    end
  endgenerate

  // report one expired tag per cycle, lowest first; others stay pending
  always_comb begin
    timer_ack = '0;
    for (int i = NUM_TAGS - 1; i >= 0; i--) begin
      if (timer_pending[i]) begin
        timer_ack = NUM_TAGS'(1) << i;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt sources and write-one-to-clear
  // ----------------------------------------------------------------
  assign irq_events[IRQ_TIMEOUT_BIT] = |timer_ack;
  assign irq_events[IRQ_FORWARD_BIT] = post_fire;
  assign irq_w1c = (wr && addr == ADDR_IRQ_STATUS) ? wdata[IRQ_W-1:0] : '0;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;

    // strap passes three flops; level moves once second and third agree
    next_state.strap_sync = {state.strap_sync[1:0], speed_66_strap};
    if (state.strap_sync[1] == state.strap_sync[2]) begin
      next_state.strap_level = state.strap_sync[2];
    end

    // register writes; reserved bits are simply not stored
    if (wr) begin
      if (addr == ADDR_CLK_STRAPS) begin
        next_state.pll_rate   = wdata[PLL_RATE_BIT];
        next_state.src_sel    = wdata[SRC_SEL_BIT];
        next_state.speed_code = wdata[SPEED_LSB +: 3];
      end else if (addr == ADDR_BUF_THRES) begin
        next_state.alloc_code = wdata[ALLOC_LSB +: 2];
        next_state.thres_code = wdata[THRES_LSB +: 5];
      end else if (addr == ADDR_COMPLETION_TIMEOUT_CONTROL) begin
        next_state.timer_en    = wdata[TIMER_EN_BIT];
        next_state.timer_value = wdata[TIMER_VALUE_LSB +: 31];
      end else if (addr == ADDR_IRQ_MASK) begin
        next_state.irq_mask = wdata[IRQ_W-1:0];
      end
    end

    // read data stand in the cycle after the strobe only
    next_state.rdata = '0;
    if (rd) begin
      if (addr == ADDR_CLK_STRAPS) begin
        next_state.rdata[PLL_RATE_BIT]     = state.pll_rate;
        next_state.rdata[SRC_SEL_BIT]      = state.src_sel;
        next_state.rdata[SPEED_LSB +: 3]   = state.speed_code;
      end else if (addr == ADDR_BUF_THRES) begin
        next_state.rdata[ALLOC_LSB +: 2]   = state.alloc_code;
        next_state.rdata[THRES_LSB +: 5]   = state.thres_code;
      end else if (addr == ADDR_COMPLETION_TIMEOUT_CONTROL) begin
        next_state.rdata[TIMER_EN_BIT]     = state.timer_en;
        next_state.rdata[TIMER_VALUE_LSB +: 31] = state.timer_value;
      end else if (addr == ADDR_IRQ_STATUS) begin
        next_state.rdata[IRQ_W-1:0] = state.irq_status;
      end else if (addr == ADDR_IRQ_MASK) begin
        next_state.rdata[IRQ_W-1:0] = state.irq_mask;
      end
    end

    // programmed speed uses only the two low code bits
    if (state.src_sel) begin
      next_state.sec_speed = bct_speed_type'(state.speed_code[1:0]);
    end else if (state.strap_level) begin
      next_state.sec_speed = SPEED_66;
    end else begin
      next_state.sec_speed = SPEED_33;
    end

    // completion buffer reservation for each non-posted read
    next_state.reserve_valid = np_issue;
    if (np_issue) begin
      next_state.reserve_bytes = (np_len < alloc_limit) ? np_len : alloc_limit;
    end

    // posted data accumulate; threshold or flush forwards them
    next_state.post_forward = 1'b0;
    if (post_sum >= {1'b0, post_threshold}) begin
      next_state.post_forward       = 1'b1;
      next_state.post_forward_bytes = post_sum;
      next_state.post_count         = 9'h000;
    end else if (post_flush && post_sum != 9'h000) begin
      next_state.post_forward       = 1'b1;
      next_state.post_forward_bytes = post_sum;
      next_state.post_count         = 9'h000;
    end else begin
      next_state.post_count = post_sum;
    end

    // expired request is handed back as an unsupported request
    next_state.completion_timeout_control = |timer_ack;
    for (int i = 0; i < NUM_TAGS; i++) begin
      if (timer_ack[i]) begin
        next_state.completion_timeout_control_tag = TAG_W'(i);
      end
    end

    // a new event wins over a clear in the same cycle
    next_state.irq_status = (state.irq_status & ~irq_w1c) | irq_events;

    // synchronous reset restores documented defaults
    if (rst) begin
      next_state             = '0;
      next_state.pll_rate    = CLK_STRAPS_RESET[PLL_RATE_BIT];
      next_state.src_sel     = CLK_STRAPS_RESET[SRC_SEL_BIT];
      next_state.speed_code  = CLK_STRAPS_RESET[SPEED_LSB +: 3];
      next_state.alloc_code  = BUF_THRES_RESET[ALLOC_LSB +: 2];
      next_state.thres_code  = BUF_THRES_RESET[THRES_LSB +: 5];
      next_state.timer_en    = COMPLETION_TIMEOUT_CONTROL_RESET[TIMER_EN_BIT];
      next_state.timer_value = COMPLETION_TIMEOUT_CONTROL_RESET[TIMER_VALUE_LSB +: 31];
      next_state.sec_speed   = SPEED_33;
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    state <= next_state;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata                 = state.rdata;
  assign irq                   = |(state.irq_status & state.irq_mask);
  assign pll_rate_select       = state.pll_rate;
  assign secondary_clock_speed = state.sec_speed;
  assign reserve_valid         = state.reserve_valid;
  assign reserve_bytes         = state.reserve_bytes;
  assign completion_timeout_control           = state.completion_timeout_control;
  assign completion_timeout_control_tag       = state.completion_timeout_control_tag;
  assign post_forward          = state.post_forward;
  assign post_forward_bytes    = state.post_forward_bytes;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_pll_rate_write:
    assert property (@(posedge clk) disable iff (rst)
      wr && addr == ADDR_CLK_STRAPS |=> pll_rate_select == $past(wdata[PLL_RATE_BIT]))
    else $error("pll rate select did not follow write");

  a_strap_speed:
    assert property (@(posedge clk) disable iff (rst)
      !state.src_sel && state.strap_level && $past(!rst) |=> secondary_clock_speed == SPEED_66)
    else $error("strap high did not give 66 MHz");

  a_prog_speed:
    assert property (@(posedge clk) disable iff (rst)
      wr && addr == ADDR_CLK_STRAPS && wdata[SRC_SEL_BIT]
      |=> ##1 secondary_clock_speed == bct_speed_type'($past(wdata[1:0], 2)))
    else $error("programmed speed not applied");

  a_speed_top_bit:
    assert property (@(posedge clk) disable iff (rst)
      state.src_sel && $stable(state.speed_code[1:0]) && $past(!rst)
      |=> secondary_clock_speed == bct_speed_type'($past(state.speed_code[1:0])))
    else $error("speed code top bit not ignored");

  a_alloc_cap:
    assert property (@(posedge clk) disable iff (rst)
      reserve_valid |-> reserve_bytes <= (ALLOC_BASE_BYTES << 3))
    else $error("reservation above 1024 bytes");

  a_reserve_min:
    assert property (@(posedge clk) disable iff (rst)
      np_issue |=> reserve_bytes == (($past(np_len) < $past(alloc_limit)) ? $past(np_len) : $past(alloc_limit)))
    else $error("reservation not minimum of limit and length");

  a_forward_thres:
    assert property (@(posedge clk) disable iff (rst)
      post_sum >= {1'b0, post_threshold} |=> post_forward && post_forward_bytes == $past(post_sum))
    else $error("threshold reached without forwarding");

  a_flush_forward:
    assert property (@(posedge clk) disable iff (rst)
      post_flush && post_sum != 9'h000 |=> post_forward && post_forward_bytes == $past(post_sum))
    else $error("flush did not forward accumulated data");

  a_thres_code:
    assert property (@(posedge clk) disable iff (rst)
      state.thres_code <= POST_MAX_CODE |-> post_threshold == 8'(state.thres_code) * 8'h10 + 8'h10)
    else $error("threshold size wrong for code");

  a_timer_disabled:
    assert property (@(posedge clk) disable iff (rst)
      !state.timer_en && $past(!state.timer_en) && $past(!state.timer_en, 2) |-> !completion_timeout_control)
    else $error("timeout reported while disabled");

  a_reset_value:
    assert property (@(posedge clk)
      rst |=> state.timer_en && state.timer_value == COMPLETION_TIMEOUT_CONTROL_RESET[30:0])
    else $error("timeout register reset value wrong");

  a_tag_busy:
    assert property (@(posedge clk) disable iff (rst)
      np_issue |=> tag_busy[$past(np_tag)])
    else $error("issued tag not timed");

  a_reserved_zero:
    assert property (@(posedge clk) disable iff (rst)
      rd && addr == ADDR_BUF_THRES |=> rdata[31:10] == '0 && rdata[7:5] == '0)
    else $error("reserved bits read nonzero");

endmodule

// [verification/bct_far_model.sv]
// far-side model: upstream reads, completions and posted beats
`timescale 1ns/10ps
module bct_far_model (
  // clock
  input  wire logic                     clk,
  // non-posted requests and completions
  output logic                          np_issue,
  output logic [bct_pkg::TAG_W-1:0]     np_tag,
  output logic [bct_pkg::LEN_W-1:0]     np_len,
  output logic                          cpl_valid,
  output logic [bct_pkg::TAG_W-1:0]     cpl_tag,
  // posted writes
  output logic                          post_valid,
  output logic [bct_pkg::BEAT_W-1:0]    post_bytes,
  output logic                          post_flush
);
  import bct_pkg::*;

  initial begin
    {np_issue, cpl_valid, post_valid, post_flush} = 4'h0;
    {np_tag, cpl_tag, np_len, post_bytes} = '0;
  end

  // k: 0 issue, 1 completion, 2 posted beat, 3 flush; one-cycle strobe
  task automatic send(input logic [1:0] k, input logic [1:0] t, input logic [12:0] v);
    @(posedge clk);
    np_issue   <= (k == 2'h0);
    cpl_valid  <= (k == 2'h1);
    post_valid <= (k == 2'h2);
    post_flush <= (k == 2'h3);
    {np_tag, cpl_tag, np_len, post_bytes} <= {t, t, v, v[7:0]};
    @(posedge clk);
    {np_issue, cpl_valid, post_valid, post_flush} <= 4'h0;
    // qualifiers go stale after the strobe, so never leave them looking valid
    {np_tag, cpl_tag, np_len, post_bytes} <= ~{t, t, v, v[7:0]};
  endtask
endmodule

// [verification/bct_regs_tb.sv]
// self-checking bench for the clock, threshold and timeout register block
`timescale 1ns/10ps
module bct_regs_tb;
  import bct_pkg::*;

  logic              clk;
  logic              rst;
  logic [11:0]       addr;
  logic [31:0]       wdata;
  logic              wr;
  logic              rd;
  logic [31:0]       rdata;
  logic              irq;
  logic              speed_66_strap;
  logic              pll_rate_select;
  bct_speed_type     secondary_clock_speed;
  logic              np_issue;
  logic [1:0]        np_tag;
  logic [12:0]       np_len;
  logic              cpl_valid;
  logic [1:0]        cpl_tag;
  logic              reserve_valid;
  logic [12:0]       reserve_bytes;
  logic [3:0]        tag_busy;
  logic              completion_timeout_control;
  logic [1:0]        completion_timeout_control_tag;
  logic              post_valid;
  logic [7:0]        post_bytes;
  logic              post_flush;
  logic              post_forward;
  logic [8:0]        post_forward_bytes;
  logic              rd_q;
  logic [31:0]       rnd;
  logic [31:0]       q_rd[$];
  logic [31:0]       q_res[$];
  logic [31:0]       q_to[$];
  logic [31:0]       q_fw[$];
  int                n_errors;
  int                n_checks;
  int                cycles;

  bct_regs u_dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .irq, .speed_66_strap, .pll_rate_select,
    .secondary_clock_speed, .np_issue, .np_tag, .np_len, .cpl_valid, .cpl_tag, .reserve_valid,
    .reserve_bytes, .tag_busy, .completion_timeout_control, .completion_timeout_control_tag, .post_valid, .post_bytes, .post_flush,
    .post_forward, .post_forward_bytes);

  bct_far_model u_far (.clk, .np_issue, .np_tag, .np_len, .cpl_valid, .cpl_tag, .post_valid,
    .post_bytes, .post_flush);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one register cycle; for a read, d is the expected word
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    if (!w) q_rd.push_back(d);
    @(posedge clk);
    {addr, wdata, wr, rd} <= {a, d, w, !w};
    @(posedge clk);
    {wr, rd} <= 2'b00;
    wdata <= ~d;
  endtask

  // let n edges pass, then step off the edge so registered outputs are settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // result watcher: every result takes the oldest note of its kind
  always @(posedge clk) begin
    rd_q <= rd;
    cycles <= cycles + 1;
    if (rd_q) chk(rdata, q_rd.size() ? q_rd.pop_front() : 'x);
    if (reserve_valid === 1'b1) chk(32'(reserve_bytes), q_res.size() ? q_res.pop_front() : 'x);
    if (completion_timeout_control === 1'b1) chk(32'(completion_timeout_control_tag), q_to.size() ? q_to.pop_front() : 'x);
    if (post_forward === 1'b1) chk(32'(post_forward_bytes), q_fw.size() ? q_fw.pop_front() : 'x);
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    {rst, addr, wdata, wr, rd, speed_66_strap, rd_q, cycles} = {1'b1, 44'h0, 4'h0, 32'h0};
    {n_errors, n_checks, rnd} = {32'h0, 32'h0, 32'h2e6a};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // reset values, reserved bits and an unmapped place
    bus(0, ADDR_CLK_STRAPS, 32'h0000_0100);
    bus(0, ADDR_BUF_THRES, 32'h0000_0307);
    bus(0, ADDR_COMPLETION_TIMEOUT_CONTROL, 32'h8009_8968);
    bus(1, 12'h054, '1);
    bus(0, 12'h054, 0);
    // reserved bits all set, defined bits random except the timeout register, written all ones
    rnd = lfsr(rnd);
    bus(1, ADDR_CLK_STRAPS, rnd | 32'hffff_fef0);
    bus(0, ADDR_CLK_STRAPS, rnd & 32'h0000_010f);
    rnd = lfsr(rnd);
    bus(1, ADDR_BUF_THRES, rnd | 32'hffff_fce0);
    bus(0, ADDR_BUF_THRES, rnd & 32'h0000_031f);
    bus(1, ADDR_COMPLETION_TIMEOUT_CONTROL, '1);
    bus(0, ADDR_COMPLETION_TIMEOUT_CONTROL, '1);
    // programmed speed: every code, both pll rates
    for (int i = 0; i < 16; i++) begin
      bus(1, ADDR_CLK_STRAPS, {23'h0, i[3], 5'h01, i[2:0]});
      settle(2);
      chk(32'(pll_rate_select), 32'(i[3]));
      chk(32'(secondary_clock_speed), 32'(i[1:0]));
    end
    // strap mode, pll rate back to its normal one; both levels, then a random one
    bus(1, ADDR_CLK_STRAPS, 32'h0000_0100);
    for (int s = 0; s < 3; s++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      speed_66_strap <= (s < 2) ? s[0] : rnd[0];
      settle(8);
      chk(32'(secondary_clock_speed), speed_66_strap ? 32'h3 : 32'h1);
    end
    // completion allocation: smaller of limit and length, each code, random tag
    bus(1, ADDR_COMPLETION_TIMEOUT_CONTROL, 32'h8000_0100);
    for (int i = 0; i < 8; i++) begin
      bus(1, ADDR_BUF_THRES, {22'h0, i[1:0], 8'h07});
      rnd = lfsr(rnd);
      q_res.push_back(i[2] ? 32'h80 << i[1:0] : (rnd[10:0] | 1) < (32'h80 << i[1:0]) ?
        32'(rnd[10:0] | 1) : 32'h80 << i[1:0]);
      u_far.send(0, rnd[12:11], i[2] ? 13'h80 << i[1:0] : 13'(rnd[10:0] | 1));
      settle(0);
      chk(32'(tag_busy), 32'h1 << rnd[12:11]);
      u_far.send(1, rnd[12:11], 0);
      settle(0);
      chk(32'(tag_busy), 0);
    end
    // posted threshold for each code, code 8 clamps to 128 bytes
    for (int c = 0; c < 9; c++) begin
      bus(1, ADDR_BUF_THRES, c);
      q_fw.push_back(c > 7 ? 128 : (c + 1) * 16);
      repeat (c > 7 ? 8 : c + 1) u_far.send(2, 0, 16);
    end
    q_fw.push_back(70);
    u_far.send(2, 0, 60);
    u_far.send(2, 0, 10);
    u_far.send(3, 0, 0);
    // a random short beat stays under the threshold until the flush
    rnd = lfsr(rnd);
    q_fw.push_back(32'(rnd[3:0]) + 1);
    u_far.send(2, 0, 13'(rnd[3:0]) + 13'h1);
    u_far.send(3, 0, 0);
    // forward status set but masked off
    settle(1);
    chk(32'(irq), 0);
    bus(0, ADDR_IRQ_STATUS, 2);
    bus(1, ADDR_IRQ_STATUS, 2);
    // expiry, early completion, zero value and disabled timer
    bus(1, ADDR_IRQ_MASK, 1);
    bus(1, ADDR_COMPLETION_TIMEOUT_CONTROL, 32'h8000_000a);
    q_res.push_back(64);
    q_to.push_back(2);
    u_far.send(0, 2, 64);
    settle(10);
    chk(32'(irq), 1);
    bus(0, ADDR_IRQ_STATUS, 1);
    bus(1, ADDR_IRQ_STATUS, 1);
    settle(1);
    chk(32'(irq), 0);
    q_res.push_back(64);
    u_far.send(0, 3, 64);
    u_far.send(1, 3, 0);
    bus(1, ADDR_COMPLETION_TIMEOUT_CONTROL, 32'h8000_0000);
    q_res.push_back(8);
    q_to.push_back(0);
    u_far.send(0, 0, 8);
    bus(1, ADDR_COMPLETION_TIMEOUT_CONTROL, 32'h0000_000a);
    q_res.push_back(8);
    u_far.send(0, 1, 8);
    settle(20);
    u_far.send(1, 1, 0);
    settle(10);
    chk(q_rd.size() + q_res.size() + q_to.size() + q_fw.size(), 0);
    conclude();
  end
endmodule
